// file: rtl/audio_repeater_mclk_gen.sv
// Audio repeater output stage with bit clock tracking and master clock generation
//
// Chosen here: the placing of the registers and the strobed register port.
`default_nettype none
// Functional notes
// - Audio forwarded from link packets by default
// - Surround setting carries all four data lines with packet transport only; frame transport carries line a alone
// - Repeater may regenerate audio from input pins
// - Software disables cleaning PLL below 1 MHz
// - Master clock is x1, x2 or x4
// - Master clock off while PLL disabled
// - Master clock defaults to twice bit clock
module audio_repeater_mclk_gen (
    input wire logic clk, // 250 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic repeater_mode, // Repeater strap pin
    input wire logic surround_autoload, // Surround mode loaded from link
    input wire logic [3:0] island_data, // One bit slot for lines a..d
    input wire logic island_valid, // Island slot valid
    output logic island_ready, // Island slot accepted
    input wire logic audio_bclk_in, // Bit clock pin
    input wire logic audio_ws_in, // Word select pin
    input wire logic audio_data_line_a_in, // Local data pin a
    input wire logic audio_data_line_b_in, // Local data pin b
    output logic audio_bclk_out, // Bit clock out
    output logic audio_ws_out, // Word select out
    output logic audio_data_line_a, // Data line a out
    output logic audio_data_line_b, // Data line b out
    output logic audio_data_line_c, // Data line c out
    output logic audio_data_line_d, // Data line d out
    output logic mclk_out // Master clock out
);
    localparam int PW = audio_rpt_pkg::PER_W;

    // Pin synchronisers: bit 4 bclk, 3 ws, 2 line a, 1 line b, 0 strap
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic bclk_d_r;
    logic bclk_rise;
    logic bclk_fall;
    logic bclk_edge;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            bclk_d_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= {audio_bclk_in, audio_ws_in, audio_data_line_a_in, audio_data_line_b_in, repeater_mode};
            pin_sync_r <= pin_meta_r;
            bclk_d_r <= pin_sync_r[4];
        end
    end

    assign bclk_rise = pin_sync_r[4] && !bclk_d_r;
    assign bclk_fall = !pin_sync_r[4] && bclk_d_r;
    assign bclk_edge = bclk_rise || bclk_fall;

    // Registers
    logic [7:0] cfg_r;
    logic override_r;
    logic [2:0] code_r;
    logic underrun_r;
    logic underrun_set;
    logic wr_cfg;
    logic wr_mclk;
    logic wr_stat;

    assign wr_cfg = reg_wr && (reg_addr == audio_rpt_pkg::ADDR_AUDIO_CFG);
    assign wr_mclk = reg_wr && (reg_addr == audio_rpt_pkg::ADDR_MCLK_CFG);
    assign wr_stat = reg_wr && (reg_addr == audio_rpt_pkg::ADDR_STATUS);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= audio_rpt_pkg::CFG_RST;
        else if (wr_cfg)
            cfg_r <= reg_wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            override_r <= 1'b0;
            code_r <= audio_rpt_pkg::MCLK_CODE_RST;
        end
        else if (wr_mclk)
        begin
            override_r <= reg_wdata[audio_rpt_pkg::MCLK_OVR_BIT];
            code_r <= reg_wdata[audio_rpt_pkg::MCLK_CODE_MSB:audio_rpt_pkg::MCLK_CODE_LSB];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            underrun_r <= 1'b0;
        else if (underrun_set)
            underrun_r <= 1'b1;
        else if (wr_stat && reg_wdata[audio_rpt_pkg::STAT_UNDERRUN_BIT])
            underrun_r <= 1'b0;
    end

    logic pll_off;
    logic frame_mode;
    logic regen_eff;
    logic surround_eff;
    logic [3:0] lane_mask;

    assign pll_off = cfg_r[audio_rpt_pkg::CFG_PLL_OFF_BIT];
    assign frame_mode = cfg_r[audio_rpt_pkg::CFG_FRAME_BIT];
    assign regen_eff = cfg_r[audio_rpt_pkg::CFG_REGEN_BIT] && pin_sync_r[0];
    assign surround_eff = (surround_autoload || cfg_r[audio_rpt_pkg::CFG_SURR_BIT]) && !frame_mode;

    // Surround only exists with packet transport; frame transport carries line a alone
    always_comb
    begin
        if (frame_mode)
            lane_mask = audio_rpt_pkg::LANES_STEREO;
        else if (surround_eff)
            lane_mask = audio_rpt_pkg::LANES_SURROUND;
        else if (cfg_r[audio_rpt_pkg::CFG_QUAD_BIT])
            lane_mask = audio_rpt_pkg::LANES_QUAD;
        else
            lane_mask = audio_rpt_pkg::LANES_STEREO;
    end

    // Bit clock period and half period measurement
    logic [PW-1:0] per_cnt_r;
    logic [PW-1:0] per_r;
    logic [PW-1:0] half_cnt_r;
    logic [PW-1:0] half_r;
    logic slow_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_cnt_r <= '0;
            per_r <= '0;
        end
        else if (bclk_rise)
        begin
            per_cnt_r <= '0;
            per_r <= per_cnt_r + 1'b1;
        end
        else if (per_cnt_r != '1)
            per_cnt_r <= per_cnt_r + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_cnt_r <= '0;
            half_r <= '0;
        end
        else if (bclk_edge)
        begin
            half_cnt_r <= '0;
            half_r <= half_cnt_r + 1'b1;
        end
        else if (half_cnt_r != '1)
            half_cnt_r <= half_cnt_r + 1'b1;
    end

    // Flags a bit clock too slow for the cleaning PLL; software acts on it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            slow_r <= 1'b0;
        else
            slow_r <= (per_r > audio_rpt_pkg::BCLK_SLOW_CYCLES) && !pll_off;
    end

    function automatic logic [2:0] rate_step(input logic [PW-1:0] per);
        logic [2:0] s;
        s = 3'h0;
        for (int k = 0; k < audio_rpt_pkg::RATE_STEPS; k++)
        begin
            if (per < (audio_rpt_pkg::RATE_STEP_THRESH >> k))
                s = 3'(k + 1);
        end
        return s;
    endfunction : rate_step

    // Multiplier: with override set, code minus the bit clock's rate step, clamped to x1..x4; x2 otherwise
    logic [2:0] step;
    logic [3:0] diff;
    logic [1:0] mult_nxt;
    logic [1:0] mult_r;

    assign step = rate_step(per_r);
    assign diff = {1'b0, code_r} - {1'b0, step};

    always_comb
    begin
        if (!override_r)
            mult_nxt = audio_rpt_pkg::MULT_X2;
        else if (diff[3])
            mult_nxt = audio_rpt_pkg::MULT_X1;
        else if (diff > 4'(audio_rpt_pkg::MULT_X4))
            mult_nxt = audio_rpt_pkg::MULT_X4;
        else
            mult_nxt = diff[1:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mult_r <= audio_rpt_pkg::MULT_X2;
        else
            mult_r <= mult_nxt;
    end

    // Master clock: toggle on each bit clock edge plus evenly spaced extra toggles
    logic [PW-1:0] sub_cnt_r;
    logic [1:0] toggles_left_r;
    logic [PW-1:0] interval;
    logic mclk_r;

    assign interval = half_r >> mult_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mclk_r <= 1'b0;
            sub_cnt_r <= '0;
            toggles_left_r <= '0;
        end
        else if (pll_off)
        begin
            mclk_r <= 1'b0;
            sub_cnt_r <= '0;
            toggles_left_r <= '0;
        end
        else if (bclk_edge)
        begin
            mclk_r <= !mclk_r;
            sub_cnt_r <= '0;
            toggles_left_r <= (2'h1 << mult_r) - 2'h1;
        end
        else if ((toggles_left_r != '0) && (interval != '0) && (sub_cnt_r + 1'b1 >= interval))
        begin
            mclk_r <= !mclk_r;
            sub_cnt_r <= '0;
            toggles_left_r <= toggles_left_r - 2'h1;
        end
        else if (sub_cnt_r != '1)
            sub_cnt_r <= sub_cnt_r + 1'b1;
    end

    assign mclk_out = mclk_r;

    // Packet samples through the FIFO, drained one slot per falling bit clock edge
    sample_fifo_if #(.WIDTH(audio_rpt_pkg::LANES), .DEPTH(audio_rpt_pkg::FIFO_DEPTH)) fq ();

    sample_fifo #(
        .WIDTH(audio_rpt_pkg::LANES),
        .DEPTH(audio_rpt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .bus(fq.fifo)
    );

    logic pop;
    assign fq.wdata = island_data;
    assign fq.wvalid = island_valid;
    assign island_ready = fq.wready;
    // Regeneration leaves the queue alone, so packets back up to the source
    assign pop = bclk_fall && !regen_eff && fq.rvalid;
    assign fq.rready = pop;
    assign underrun_set = bclk_fall && !regen_eff && !fq.rvalid;

    logic [3:0] lines_r;
    logic bclk_out_r;
    logic ws_out_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lines_r <= '0;
        else if (bclk_fall)
        begin
            if (regen_eff)
                lines_r <= {2'b00, pin_sync_r[1], pin_sync_r[2]};
            else if (fq.rvalid)
                lines_r <= fq.rdata & lane_mask;
            else
                lines_r <= '0;
        end
    end

    // Bit clock and word select delayed once to stay aligned with the data lines
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bclk_out_r <= 1'b0;
            ws_out_r <= 1'b0;
        end
        else
        begin
            bclk_out_r <= pin_sync_r[4];
            ws_out_r <= pin_sync_r[3];
        end
    end

    assign audio_bclk_out = bclk_out_r;
    assign audio_ws_out = ws_out_r;
    assign audio_data_line_a = lines_r[0];
    assign audio_data_line_b = lines_r[1];
    assign audio_data_line_c = lines_r[2];
    assign audio_data_line_d = lines_r[3];

    // Register read, one cycle after the strobe and only then
    logic [7:0] rdata_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= '0;
        else if (!reg_rd)
            rdata_r <= '0;
        else if (reg_addr == audio_rpt_pkg::ADDR_AUDIO_CFG)
            rdata_r <= cfg_r;
        else if (reg_addr == audio_rpt_pkg::ADDR_MCLK_CFG)
            rdata_r <= {override_r, code_r, 4'h0};
        else if (reg_addr == audio_rpt_pkg::ADDR_STATUS)
            rdata_r <= {3'h0, underrun_r, slow_r, mult_r, !pll_off};
        else if (reg_addr == audio_rpt_pkg::ADDR_RATE)
            rdata_r <= {fq.level, 1'b0, step};
        else
            rdata_r <= '0;
    end
    assign reg_rdata = rdata_r;

    // Helper: master clock toggles seen since the last bit clock edge
    logic [2:0] tog_seen_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tog_seen_r <= '0;
        else if (bclk_edge)
            tog_seen_r <= '0;
        else if (mclk_r != $past(mclk_r) && tog_seen_r != '1)
            tog_seen_r <= tog_seen_r + 3'h1;
    end

    // Ratio that armed the current half period; a mid-period change must not count
    logic [1:0] mult_edge_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mult_edge_r <= audio_rpt_pkg::MULT_X2;
        else if (bclk_edge)
            mult_edge_r <= mult_r;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_island_pop_source: assert property (fq.rready |-> bclk_fall && !regen_eff)
        else $error("FIFO popped outside a falling bit clock edge or during regeneration");
    chk_surround_line_d: assert property (bclk_fall && !regen_eff && fq.rvalid && surround_eff
        |=> audio_data_line_d == $past(fq.rdata[3]))
        else $error("Surround slot did not reach line d");
    chk_frame_lanes_off: assert property (bclk_fall && frame_mode && !regen_eff
        |=> !audio_data_line_b && !audio_data_line_c && !audio_data_line_d)
        else $error("Frame transport drove lines other than a");
    chk_regen_pins: assert property (bclk_fall && regen_eff
        |=> audio_data_line_a == $past(pin_sync_r[2]) && audio_data_line_b == $past(pin_sync_r[1]))
        else $error("Regenerated lines do not follow the input pins");
    chk_pll_disable_write: assert property (wr_cfg ##1 1'b1
        |-> pll_off == $past(reg_wdata[audio_rpt_pkg::CFG_PLL_OFF_BIT]))
        else $error("PLL disable bit not taken from write");
    chk_mclk_toggle_count: assert property (bclk_edge && !pll_off && $past(!pll_off, 2)
        |-> tog_seen_r <= (3'h1 << mult_edge_r))
        else $error("Too many master clock toggles per bit clock half period");
    chk_mclk_off_disabled: assert property (pll_off ##1 pll_off |-> !mclk_out [*1])
        else $error("Master clock running while PLL disabled");
    chk_default_mult_x2: assert property (!override_r ##1 1'b1 |-> mult_r == audio_rpt_pkg::MULT_X2)
        else $error("Master clock ratio is not x2 without override");
    chk_code_ignored: assert property (!override_r && wr_mclk && !reg_wdata[7] |=> ##1 mult_r == 2'h1)
        else $error("Ratio code applied while override clear");
    chk_read_timing: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("Read data present without a read strobe");

    cov_surround_pop: cover property (pop && surround_eff);
    cov_regen_active: cover property (bclk_fall && regen_eff);
    cov_mult_x4: cover property (override_r && mult_r == audio_rpt_pkg::MULT_X4 && bclk_edge);
    cov_fifo_full: cover property (!island_ready && island_valid);
endmodule : audio_repeater_mclk_gen
`default_nettype wire

// file: rtl/audio_rpt_pkg.sv
// Constants shared by the audio repeater and master clock generator
`default_nettype none
package audio_rpt_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_AUDIO_CFG = 8'h2B;
    localparam logic [7:0] ADDR_MCLK_CFG = 8'h3A;
    localparam logic [7:0] ADDR_STATUS = 8'h3C;
    localparam logic [7:0] ADDR_RATE = 8'h3D;
    // Audio configuration fields
    localparam int CFG_PLL_OFF_BIT = 7;
    localparam int CFG_REGEN_BIT = 3;
    localparam int CFG_QUAD_BIT = 2;
    localparam int CFG_SURR_BIT = 1;
    localparam int CFG_FRAME_BIT = 0;
    localparam logic [7:0] CFG_RST = 8'h00;
    // Master clock configuration fields
    localparam int MCLK_OVR_BIT = 7;
    localparam int MCLK_CODE_MSB = 6;
    localparam int MCLK_CODE_LSB = 4;
    localparam logic [2:0] MCLK_CODE_RST = 3'h1;
    // Status fields
    localparam int STAT_PLL_ON_BIT = 0;
    localparam int STAT_MULT_LSB = 1;
    localparam int STAT_MULT_MSB = 2;
    localparam int STAT_SLOW_BIT = 3;
    localparam int STAT_UNDERRUN_BIT = 4;
    localparam int RATE_STEP_MSB = 2;
    localparam int RATE_LEVEL_LSB = 4;
    // Multiplier as log2
    localparam logic [1:0] MULT_X1 = 2'h0;
    localparam logic [1:0] MULT_X2 = 2'h1;
    localparam logic [1:0] MULT_X4 = 2'h2;
    // Data path
    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] LANES_STEREO = 4'h1;
    localparam logic [3:0] LANES_QUAD = 4'h3;
    localparam logic [3:0] LANES_SURROUND = 4'hF;
    // Timing
    localparam int PER_W = 12;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BCLK_MIN_KHZ = 1000;
    localparam int BCLK_REF_KHZ = 1536;
    localparam logic [PER_W-1:0] BCLK_SLOW_CYCLES = PER_W'(1_000_000_000 / (BCLK_MIN_KHZ * CLK_PERIOD_PS));
    localparam int BCLK_REF_CYCLES = 1_000_000_000 / (BCLK_REF_KHZ * CLK_PERIOD_PS);
    // Step boundary sits halfway (geometric) between neighbouring rates
    localparam logic [PER_W-1:0] RATE_STEP_THRESH = PER_W'(BCLK_REF_CYCLES * 181 / 256);
    localparam int RATE_STEPS = 5;
endpackage : audio_rpt_pkg
`default_nettype wire

// file: rtl/sample_fifo_if.sv
// Valid/ready carrier between the repeater and its sample FIFO
`default_nettype none
interface sample_fifo_if #(parameter int WIDTH = 4, parameter int DEPTH = 8);
    logic [WIDTH-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [WIDTH-1:0] rdata;
    logic rvalid;
    logic rready;
    logic [$clog2(DEPTH):0] level;
    modport fifo (input wdata, input wvalid, output wready,
                  output rdata, output rvalid, input rready, output level);
    modport user (output wdata, output wvalid, input wready,
                  input rdata, input rvalid, output rready, input level);
endinterface : sample_fifo_if
`default_nettype wire

// file: rtl/sample_fifo.sv
// Flip-flop FIFO with a registered full flag; empty is decoded from the registered count
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    sample_fifo_if.fifo bus // Push and pop sides
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    assign push = bus.wvalid && bus.wready;
    assign pop = bus.rvalid && bus.rready;
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    assign bus.rdata = mem_r[rptr_r];
    assign bus.level = count_r;
    assign bus.rvalid = (count_r != '0);

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wptr_r] <= bus.wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
            bus.wready <= 1'b0;
        end
        else
        begin
            if (push)
                wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
            if (pop)
                rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
            count_r <= count_nxt;
            // Registered from the next count, so the source sees full in the cycle the FIFO fills, never late
            bus.wready <= (count_nxt < DEPTH_V);
        end
    end
endmodule : sample_fifo
`default_nettype wire

// file: dv/audio_src_model.sv
// Pin-side audio source: bit clock, word select and local data pins
`default_nettype none
module audio_src_model #(
    parameter realtime HALF = 62.5
) (
    input wire logic run, // Bit clock runs while high
    input wire logic pat_a, // Level for local data pin a
    input wire logic pat_b, // Level for local data pin b
    output logic bclk, // Bit clock pin
    output logic ws, // Word select pin
    output logic data_a, // Local data pin a
    output logic data_b // Local data pin b
);
    timeunit 1ns;
    timeprecision 100ps;
    int bits;
    initial
    begin
        bclk = 1'b0;
        ws = 1'b0;
        data_a = 1'b0;
        data_b = 1'b0;
        bits = 0;
        forever
        begin
            #HALF;
            // Finish the period, then stand low while stopped
            if (run || bclk)
                bclk = ~bclk;
            if (run && !bclk)
            begin
                bits = (bits + 1) % 16;
                if (bits == 0)
                    ws = ~ws;
                data_a = pat_a;
                data_b = pat_b;
            end
        end
    end
endmodule : audio_src_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the audio repeater and master clock generator
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, reg_wr, reg_rd, repeater_mode, surround_autoload, island_valid, island_ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] island_data;
    logic bclk, ws, da, db, bclk_o, ws_o, la, lb, lc, ld, mclk, run, pat_a, pat_b, mclk_q, bclk_q;
    int errors, compares, cyc, mrise, brise, step;
    audio_src_model audio_src_model_inst (.run(run), .pat_a(pat_a), .pat_b(pat_b), .bclk(bclk), .ws(ws),
        .data_a(da), .data_b(db));
    audio_repeater_mclk_gen audio_repeater_mclk_gen_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .repeater_mode(repeater_mode), .surround_autoload(surround_autoload), .island_data(island_data),
        .island_valid(island_valid), .island_ready(island_ready), .audio_bclk_in(bclk), .audio_ws_in(ws),
        .audio_data_line_a_in(da), .audio_data_line_b_in(db), .audio_bclk_out(bclk_o), .audio_ws_out(ws_o),
        .audio_data_line_a(la), .audio_data_line_b(lb), .audio_data_line_c(lc), .audio_data_line_d(ld),
        .mclk_out(mclk));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        mclk_q <= mclk;
        bclk_q <= bclk_o;
        if (mclk && !mclk_q)
            mrise <= mrise + 1;
        if (bclk_o && !bclk_q)
            brise <= brise + 1;
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d & mask, exp);
    endtask : rd_chk
    // Rise-count window opens on a clock cycle and closes on the eighth bit clock rise, one count of slack
    task automatic meas(input int m);
        int r0, b0, n, got;
        repeat (130) @(posedge clk);
        b0 = brise;
        r0 = mrise;
        n = 0;
        while (brise < b0 + 8 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        got = mrise - r0;
        if (got >= (8 << m) - 1 && got <= (8 << m) + 1)
            got = 8 << m;
        check(8'(got), 8'(8 << m));
        rd_chk(audio_rpt_pkg::ADDR_STATUS, 8'h06, 8'(m << 1));
    endtask : meas
    task automatic t_regs();
        rd_chk(audio_rpt_pkg::ADDR_AUDIO_CFG, 8'hFF, 8'h00);
        rd_chk(audio_rpt_pkg::ADDR_MCLK_CFG, 8'hFF, 8'h10);
        rd_chk(8'h55, 8'hFF, 8'h00);
        wr(8'h55, 8'hFF);
        wr(audio_rpt_pkg::ADDR_MCLK_CFG, 8'h3F);
        rd_chk(audio_rpt_pkg::ADDR_MCLK_CFG, 8'hFF, 8'h30);
        $display("test regs done");
    endtask : t_regs
    task automatic t_default();
        int c0, th;
        meas(1);
        c0 = cyc;
        brise = brise;
        repeat (256) @(posedge clk);
        th = int'(audio_rpt_pkg::RATE_STEP_THRESH);
        step = 0;
        while (250 / 8 < th && step < 7)
        begin
            step++;
            th = th / 2;
        end
        rd_chk(audio_rpt_pkg::ADDR_RATE, 8'h07, 8'(step));
        $display("test default done");
    endtask : t_default
    task automatic t_ratio();
        int m;
        for (int c = 0; c < 8; c++)
        begin
            m = c - step;
            m = m < 0 ? 0 : (m > 2 ? 2 : m);
            wr(audio_rpt_pkg::ADDR_MCLK_CFG, 8'h80 | 8'(c << 4));
            meas(m);
        end
        wr(audio_rpt_pkg::ADDR_MCLK_CFG, 8'h00);
        meas(1);
        $display("test ratio done");
    endtask : t_ratio
    task automatic t_pll();
        int m0;
        wr(audio_rpt_pkg::ADDR_AUDIO_CFG, 8'h80);
        m0 = mrise;
        repeat (300) @(posedge clk);
        check(8'(mrise - m0), 8'h00);
        rd_chk(audio_rpt_pkg::ADDR_STATUS, 8'h01, 8'h00);
        wr(audio_rpt_pkg::ADDR_AUDIO_CFG, 8'h00);
        meas(1);
        $display("test pll done");
    endtask : t_pll
    task automatic lanes(input logic [7:0] cfg, input logic auto, input logic [3:0] d, input logic [3:0] exp);
        run <= 1'b0;
        surround_autoload <= auto;
        wr(audio_rpt_pkg::ADDR_AUDIO_CFG, cfg);
        repeat (40) @(posedge clk);
        island_data <= d;
        island_valid <= 1'b1;
        repeat (9) @(posedge clk);
        island_valid <= 1'b0;
        island_data <= ~d;
        #1;
        check({7'h0, island_ready}, 8'h00);
        @(posedge clk);
        rd_chk(audio_rpt_pkg::ADDR_RATE, 8'hF0, 8'h80);
        run <= 1'b1;
        repeat (100) @(posedge clk);
        check({4'h0, ld, lc, lb, la}, {4'h0, exp});
        repeat (300) @(posedge clk);
    endtask : lanes
    task automatic t_lanes();
        lanes(8'h00, 1'b0, 4'hF, 4'h1);
        lanes(8'h04, 1'b0, 4'hF, 4'h3);
        lanes(8'h00, 1'b1, 4'h5, 4'h5);
        lanes(8'h02, 1'b0, 4'hA, 4'hA);
        lanes(8'h03, 1'b0, 4'hF, 4'h1);
        check({4'h0, ld, lc, lb, la}, 8'h00);
        rd_chk(audio_rpt_pkg::ADDR_STATUS, 8'h10, 8'h10);
        run <= 1'b0;
        surround_autoload <= 1'b0;
        repeat (40) @(posedge clk);
        wr(audio_rpt_pkg::ADDR_STATUS, 8'h10);
        rd_chk(audio_rpt_pkg::ADDR_STATUS, 8'h10, 8'h00);
        run <= 1'b1;
        $display("test lanes done");
    endtask : t_lanes
    task automatic t_regen();
        repeater_mode <= 1'b1;
        wr(audio_rpt_pkg::ADDR_AUDIO_CFG, 8'h08);
        pat_a <= 1'b1;
        repeat (150) @(posedge clk);
        check({6'h0, lb, la}, 8'h01);
        pat_a <= 1'b0;
        pat_b <= 1'b1;
        repeat (150) @(posedge clk);
        check({6'h0, lb, la}, 8'h02);
        repeater_mode <= 1'b0;
        // Word select passes through three flops; look once it has settled
        @(ws);
        repeat (5) @(posedge clk);
        check({7'h0, ws_o}, {7'h0, ws});
        $display("test regen done");
    endtask : t_regen
    initial
    begin
        {rst_n, reg_wr, reg_rd, repeater_mode, surround_autoload, island_valid, pat_a, pat_b} = '0;
        {reg_addr, reg_wdata, island_data, errors, compares, cyc, mrise, brise} = '0;
        {mclk_q, bclk_q} = '0;
        run = 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_default();
        t_ratio();
        t_pll();
        t_lanes();
        t_regen();
        summarize();
    end
endmodule : testbench
`default_nettype wire
